// ===== verilog/pfp_pkg.sv
// constants shared by the printer front panel controller
package pfp_pkg;

  // register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_COUNT = 8'h08;

  // control register fields and value after reset
  localparam int CTRL_KEYS_OFF_BIT = 0;
  localparam int CTRL_TOGGLE_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;

  // status register field positions
  localparam int ST_STATE_LSB = 0;
  localparam int ST_RAWMODE_BIT = 2;
  localparam int ST_PAPEROUT_BIT = 3;
  localparam int ST_SLOT_BIT = 4;
  localparam int ST_FEED_BIT = 5;
  localparam int ST_JUMPER_LSB = 8;

  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // pin bundle layout and idle levels after reset
  localparam int PIN_ONLINE_KEY = 0;
  localparam int PIN_FEED_KEY = 1;
  localparam int PIN_PAPER_OUT = 2;
  localparam int PIN_JUMPER_LSB = 3;
  localparam int PIN_STROBE = 7;
  localparam int PIN_DATA_LSB = 8;
  localparam int PIN_COUNT = 16;
  localparam logic [15:0] PIN_IDLE = 16'h0083;

  // timing
  localparam int CLK_MHZ = 125;
  localparam int DEBOUNCE_US = 10000;
  localparam int DEBOUNCE_CYCLES = DEBOUNCE_US * CLK_MHZ;
  localparam int ACK_NS = 5000;
  localparam int ACK_CYCLES = (ACK_NS * CLK_MHZ + 999) / 1000;
  localparam logic [2:0] STRAP_WAIT = 3'h4;

  // self-test character range
  localparam logic [7:0] TEST_FIRST = 8'h20;
  localparam logic [7:0] TEST_LAST = 8'h7e;

  typedef enum logic [1:0] {
    ST_ONLINE,
    ST_PAUSING,
    ST_OFFLINE,
    ST_SELFTEST
  } pfp_state_t;

endpackage

// ===== verilog/pfp_panel.sv
// printer front panel control: keys, lamp, jumpers, host byte gate, self-test
//
// Notes on behaviour
// - lamp red offline no paper, green online, yellow online no paper, else dark; green and yellow go dark while a host byte waits in the slot
// - enters online after reset and on leaving self-test
// - idle online-toggle press alternates online and offline
// - host bytes are refused while offline
// - press while printing finishes the row, then goes offline; next press resumes
// - online key held at reset selects raw-byte mode, bytes printed as hex
// - offline with feed key held feeds paper; release stops; online no feed
// - offline, feed key held, online-toggle press starts self-test
// - self-test prints every valid character with no host data
// - self-test ends after the last character or on an online-toggle press
// - command-set jumper open selects set A, fitted selects set B
// - charset jumper open selects ASCII, fitted selects Chinese
// - direction jumper open prints reversed, fitted prints normal
// - font jumper 1-2 selects small font, 2-3 selects large font
// - host data arrives one byte at a time on an 8-bit port
//
// The address map and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/10ps
module pfp_panel #(
  parameter int DEBOUNCE_CYCLES = pfp_pkg::DEBOUNCE_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // front panel pins, keys active low
  input wire logic onlineKeyN,
  input wire logic paperFeedKeyN,
  input wire logic paperOut,
  output logic lampRed,
  output logic lampGreen,
  // jumper pins, high when fitted; font high when linking 2-3
  input wire logic commandSetJumper,
  input wire logic charsetJumper,
  input wire logic directionJumper,
  input wire logic fontJumper,
  // parallel host port
  input wire logic [7:0] hostData,
  input wire logic hostStrobeN,
  output logic hostBusy,
  output logic hostAckN,
  // print engine, same clock
  output logic [7:0] printByte,
  output logic printValid,
  input wire logic printReady,
  input wire logic rowActive,
  output logic feedMotor,
  output logic rawBytePrintMode,
  output logic commandSetB,
  output logic chineseMode,
  output logic reverseDirection,
  output logic largeFont,
  output logic selfTestActive
);

  localparam int DBW = $clog2(DEBOUNCE_CYCLES + 1);
  localparam int AKW = $clog2(pfp_pkg::ACK_CYCLES + 1);

  function automatic logic [7:0] hexChar(input logic [3:0] nib);
    hexChar = (nib < 4'ha) ? {4'h3, nib} : 8'(8'h57 + {4'h0, nib});
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: a level counts once stages two and three agree
  logic [15:0] pinBus;
  logic [15:0] sync1;
  logic [15:0] sync2;
  logic [15:0] sync3;
  logic [15:0] pinLevel;
  assign pinBus = {hostData, hostStrobeN, fontJumper, directionJumper, charsetJumper,
                   commandSetJumper, paperOut, paperFeedKeyN, onlineKeyN};

  genvar gi;
  generate
    for (gi = 0; gi < pfp_pkg::PIN_COUNT; gi++) begin : g_sync
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          sync1[gi] <= pfp_pkg::PIN_IDLE[gi];
          sync2[gi] <= pfp_pkg::PIN_IDLE[gi];
          sync3[gi] <= pfp_pkg::PIN_IDLE[gi];
          pinLevel[gi] <= pfp_pkg::PIN_IDLE[gi];
        end else begin
          sync1[gi] <= pinBus[gi];
          sync2[gi] <= sync1[gi];
          sync3[gi] <= sync2[gi];
          if (sync2[gi] == sync3[gi]) begin
            pinLevel[gi] <= sync3[gi];
          end
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // key debounce, one counter per key
  logic [1:0] keyHeld;
  logic [1:0] keyPress;
  logic [DBW-1:0] dbCnt [2];
  generate
    for (gi = 0; gi < 2; gi++) begin : g_key
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          dbCnt[gi] <= '0;
          keyHeld[gi] <= 1'b0;
          keyPress[gi] <= 1'b0;
        end else begin
          keyPress[gi] <= 1'b0;
          if (!pinLevel[gi] == keyHeld[gi]) begin
            dbCnt[gi] <= '0;
          end else if (dbCnt[gi] == DBW'(DEBOUNCE_CYCLES - 1)) begin
            dbCnt[gi] <= '0;
            keyHeld[gi] <= !pinLevel[gi];
            keyPress[gi] <= !pinLevel[gi];
          end else begin
            dbCnt[gi] <= dbCnt[gi] + DBW'(1);
          end
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // strap capture after reset release
  logic [2:0] strapCnt;
  logic strapped;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      strapCnt <= 3'h0;
      strapped <= 1'b0;
      rawBytePrintMode <= 1'b0;
    end else if (!strapped) begin
      strapCnt <= strapCnt + 3'h1;
      if (strapCnt == pfp_pkg::STRAP_WAIT) begin
        strapped <= 1'b1;
        // raw pin level: debounce has not settled this early
        rawBytePrintMode <= !pinLevel[pfp_pkg::PIN_ONLINE_KEY];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control register
  logic keysOff;
  logic softToggle;
  logic togglePress;
  logic feedHeld;
  assign togglePress = (keyPress[0] && !keysOff) || softToggle;
  assign feedHeld = keyHeld[1] && !keysOff;

  ////////////////////////////////////////////////////////////////////////////
  // operating state
  pfp_pkg::pfp_state_t state;
  logic testDone;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= pfp_pkg::ST_ONLINE;
    end else if (strapped) begin
      unique case (state)
        pfp_pkg::ST_ONLINE: begin
          if (togglePress) begin
            state <= rowActive ? pfp_pkg::ST_PAUSING : pfp_pkg::ST_OFFLINE;
          end
        end
        pfp_pkg::ST_PAUSING: begin
          if (!rowActive) begin
            state <= pfp_pkg::ST_OFFLINE;
          end
        end
        pfp_pkg::ST_OFFLINE: begin
          if (togglePress) begin
            state <= feedHeld ? pfp_pkg::ST_SELFTEST : pfp_pkg::ST_ONLINE;
          end
        end
        pfp_pkg::ST_SELFTEST: begin
          if (togglePress || testDone) begin
            state <= pfp_pkg::ST_ONLINE;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // host byte slot and acknowledge
  logic strobeLast;
  logic slotFull;
  logic [7:0] slotData;
  logic slotRelease;
  logic takeByte;
  logic [AKW-1:0] ackCnt;
  logic [31:0] byteCount;
  assign takeByte = strapped && strobeLast && !pinLevel[pfp_pkg::PIN_STROBE]
                    && state == pfp_pkg::ST_ONLINE && !slotFull && ackCnt == '0;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      strobeLast <= 1'b1;
      slotFull <= 1'b0;
      slotData <= 8'h00;
      byteCount <= 32'h0000_0000;
    end else begin
      strobeLast <= pinLevel[pfp_pkg::PIN_STROBE];
      if (takeByte) begin
        slotFull <= 1'b1;
        slotData <= pinLevel[pfp_pkg::PIN_DATA_LSB +: 8];
        byteCount <= byteCount + 32'h1;
      end else if (slotRelease) begin
        slotFull <= 1'b0;
      end
    end
  end

  // busy stays high offline so the host holds its next byte
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ackCnt <= '0;
      hostAckN <= 1'b1;
      hostBusy <= 1'b1;
    end else begin
      if (slotRelease) begin
        ackCnt <= AKW'(pfp_pkg::ACK_CYCLES);
      end else if (ackCnt != '0) begin
        ackCnt <= ackCnt - AKW'(1);
      end
      hostAckN <= !(slotRelease || ackCnt > AKW'(1));
      hostBusy <= !strapped || state != pfp_pkg::ST_ONLINE || slotFull || takeByte
                  || slotRelease || ackCnt != '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // print byte emitter: host bytes, hex pairs or self-test listing
  logic fromHost;
  logic hexLow;
  logic [7:0] testChar;
  logic accepted;
  assign accepted = printValid && printReady;
  assign slotRelease = accepted && fromHost && (!rawBytePrintMode || hexLow);
  assign testDone = accepted && !fromHost && printByte == pfp_pkg::TEST_LAST;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      printValid <= 1'b0;
      printByte <= 8'h00;
      fromHost <= 1'b0;
      hexLow <= 1'b0;
      testChar <= pfp_pkg::TEST_FIRST;
    end else if (accepted) begin
      printValid <= 1'b0;
      if (fromHost && rawBytePrintMode && !hexLow) begin
        printValid <= 1'b1;
        printByte <= hexChar(slotData[3:0]);
        hexLow <= 1'b1;
      end
    end else if (!printValid) begin
      if (state == pfp_pkg::ST_ONLINE && slotFull) begin
        printValid <= 1'b1;
        fromHost <= 1'b1;
        hexLow <= 1'b0;
        printByte <= rawBytePrintMode ? hexChar(slotData[7:4]) : slotData;
      end else if (state == pfp_pkg::ST_SELFTEST) begin
        printValid <= 1'b1;
        fromHost <= 1'b0;
        printByte <= testChar;
        testChar <= (testChar == pfp_pkg::TEST_LAST) ? pfp_pkg::TEST_FIRST
                    : testChar + 8'h01;
      end else begin
        testChar <= pfp_pkg::TEST_FIRST;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // lamp, feed and jumper-driven modes
  logic offline;
  assign offline = state == pfp_pkg::ST_OFFLINE;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lampRed <= 1'b0;
      lampGreen <= 1'b0;
      feedMotor <= 1'b0;
      selfTestActive <= 1'b0;
    end else begin
      // yellow is red and green together
      lampRed <= pinLevel[pfp_pkg::PIN_PAPER_OUT]
                 && (offline || (state == pfp_pkg::ST_ONLINE && !slotFull));
      lampGreen <= state == pfp_pkg::ST_ONLINE && !slotFull && strapped;
      feedMotor <= offline && feedHeld;
      selfTestActive <= state == pfp_pkg::ST_SELFTEST;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      commandSetB <= 1'b0;
      chineseMode <= 1'b0;
      reverseDirection <= 1'b1;
      largeFont <= 1'b0;
    end else begin
      commandSetB <= pinLevel[pfp_pkg::PIN_JUMPER_LSB];
      chineseMode <= pinLevel[pfp_pkg::PIN_JUMPER_LSB + 1];
      reverseDirection <= !pinLevel[pfp_pkg::PIN_JUMPER_LSB + 2];
      largeFont <= pinLevel[pfp_pkg::PIN_JUMPER_LSB + 3];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite write path
  logic awHave;
  logic wHave;
  logic [7:0] awAddr;
  logic [31:0] wData;
  logic [3:0] wStrb;
  logic doWrite;
  logic next_awHave;
  logic next_wHave;
  assign doWrite = awHave && wHave && !s_axi_bvalid;
  assign next_awHave = (awHave && !doWrite) || (s_axi_awready && s_axi_awvalid);
  assign next_wHave = (wHave && !doWrite) || (s_axi_wready && s_axi_wvalid);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      awHave <= 1'b0;
      wHave <= 1'b0;
      awAddr <= 8'h00;
      wData <= 32'h0000_0000;
      wStrb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= pfp_pkg::RESP_OKAY;
    end else begin
      awHave <= next_awHave;
      wHave <= next_wHave;
      s_axi_awready <= !next_awHave;
      s_axi_wready <= !next_wHave;
      if (s_axi_awready && s_axi_awvalid) begin
        awAddr <= s_axi_awaddr;
      end
      if (s_axi_wready && s_axi_wvalid) begin
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
      end
      if (doWrite) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awAddr == pfp_pkg::ADDR_CTRL || awAddr == pfp_pkg::ADDR_STATUS
                        || awAddr == pfp_pkg::ADDR_COUNT) ? pfp_pkg::RESP_OKAY
                       : pfp_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // toggle bit acts like one panel press and reads back as zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      keysOff <= pfp_pkg::CTRL_RESET[pfp_pkg::CTRL_KEYS_OFF_BIT];
      softToggle <= pfp_pkg::CTRL_RESET[pfp_pkg::CTRL_TOGGLE_BIT];
    end else begin
      softToggle <= 1'b0;
      if (doWrite && awAddr == pfp_pkg::ADDR_CTRL && wStrb[0]) begin
        keysOff <= wData[pfp_pkg::CTRL_KEYS_OFF_BIT];
        softToggle <= wData[pfp_pkg::CTRL_TOGGLE_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite read path
  logic [31:0] statusWord;
  always_comb begin
    statusWord = 32'h0000_0000;
    statusWord[pfp_pkg::ST_STATE_LSB +: 2] = state;
    statusWord[pfp_pkg::ST_RAWMODE_BIT] = rawBytePrintMode;
    statusWord[pfp_pkg::ST_PAPEROUT_BIT] = pinLevel[pfp_pkg::PIN_PAPER_OUT];
    statusWord[pfp_pkg::ST_SLOT_BIT] = slotFull;
    statusWord[pfp_pkg::ST_FEED_BIT] = feedMotor;
    statusWord[pfp_pkg::ST_JUMPER_LSB +: 4] = pinLevel[pfp_pkg::PIN_JUMPER_LSB +: 4];
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= pfp_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arready && s_axi_arvalid);
      if (s_axi_arready && s_axi_arvalid) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= pfp_pkg::RESP_OKAY;
        unique case (s_axi_araddr)
          pfp_pkg::ADDR_CTRL: s_axi_rdata <= {31'h0, keysOff};
          pfp_pkg::ADDR_STATUS: s_axi_rdata <= statusWord;
          pfp_pkg::ADDR_COUNT: s_axi_rdata <= byteCount;
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= pfp_pkg::RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

// ===== tb/pfp_panel_sva.sv
// assertion checker for the printer front panel block
`timescale 1ns/10ps
module pfp_panel_sva #(
  parameter int DEBOUNCE_CYCLES = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // panel and jumpers
  input wire logic paperFeedKeyN,
  input wire logic lampRed,
  input wire logic lampGreen,
  input wire logic fontJumper,
  input wire logic directionJumper,
  // host port and engine
  input wire logic hostBusy,
  input wire logic hostAckN,
  input wire logic [7:0] printByte,
  input wire logic printValid,
  input wire logic printReady,
  input wire logic feedMotor,
  input wire logic rawBytePrintMode,
  input wire logic largeFont,
  input wire logic reverseDirection,
  input wire logic selfTestActive
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  int keyUp;
  int ackLen;
  int since;
  ////////////////////////////////////////////////////////////
  // helper counts: sync plus debounce latency is far below the key-up limit
  always_ff @(posedge clk or posedge rst) begin
    if (rst || !paperFeedKeyN) keyUp <= 0;
    else if (keyUp < 63) keyUp <= keyUp + 1;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst || hostAckN) ackLen <= 0;
    else ackLen <= ackLen + 1;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) since <= 0;
    else if (since < 15) since <= since + 1;
  end
  ////////////////////////////////////////////////////////////
  a_red_offline: assert property (lampRed && !lampGreen |-> hostBusy)
    else $error("red lamp while accepting bytes");
  a_online_lit: assert property (!hostBusy |-> ##[0:2] lampGreen)
    else $error("byte accepted without green lamp");
  a_print_hold: assert property (printValid && !printReady |=> printValid && $stable(printByte))
    else $error("print byte dropped before taken");
  a_ack_cause: assert property ($fell(hostAckN) |-> $past(printValid && printReady))
    else $error("ack without engine take");
  a_ack_long: assert property ($rose(hostAckN) |-> ackLen >= 620 && ackLen <= 630)
    else $error("ack pulse width wrong");
  a_ack_busy: assert property (!hostAckN |-> hostBusy)
    else $error("not busy during ack");
  a_test_chars: assert property (selfTestActive && printValid |-> printByte inside {[8'h20:8'h7e]})
    else $error("self-test byte out of range");
  a_feed_stop: assert property (keyUp == DEBOUNCE_CYCLES + 8 |-> !feedMotor)
    else $error("feed runs after key release");
  a_strap_hold: assert property (since == 15 |-> $stable(rawBytePrintMode))
    else $error("raw mode changed after power-up");
  a_font_follow: assert property ($rose(fontJumper) |-> ##[1:6] largeFont)
    else $error("large font not selected");
  a_dir_follow: assert property ($fell(directionJumper) |-> ##[1:6] reverseDirection)
    else $error("reverse direction not selected");
  c_selftest: cover property ($rose(selfTestActive));
  c_ack: cover property ($fell(hostAckN));
  c_feed: cover property ($rose(feedMotor));
endmodule

bind pfp_panel pfp_panel_sva #(.DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)) u_pfp_panel_sva (
  .clk(clk), .rst(rst), .paperFeedKeyN(paperFeedKeyN), .lampRed(lampRed),
  .lampGreen(lampGreen), .fontJumper(fontJumper), .directionJumper(directionJumper),
  .hostBusy(hostBusy), .hostAckN(hostAckN), .printByte(printByte), .printValid(printValid),
  .printReady(printReady), .feedMotor(feedMotor), .rawBytePrintMode(rawBytePrintMode),
  .largeFont(largeFont), .reverseDirection(reverseDirection), .selfTestActive(selfTestActive)
);

// ===== tb/pfp_host_model.sv
// host processor model on the parallel print port
`timescale 1ns/10ps
module pfp_host_model (
  // clock
  input wire logic clk,
  // parallel port
  input wire logic hostBusy,
  output logic [7:0] hostData,
  output logic hostStrobeN
);
  initial begin
    hostData = 8'h00;
    hostStrobeN = 1'b1;
  end
  // one byte per strobe; forced ignores busy to provoke a refusal
  task automatic send(input logic [7:0] b, input logic forced);
    do @(posedge clk); while (!forced && hostBusy !== 1'b0);
    hostData <= b;
    repeat (2) @(posedge clk);
    hostStrobeN <= 1'b0;
    repeat (12) @(posedge clk);
    hostStrobeN <= 1'b1;
    repeat (12) @(posedge clk);
    // released: never leave the old byte looking valid
    hostData <= ~b;
  endtask
endmodule

// ===== tb/pfp_panel_test.sv
// self-checking bench for the printer front panel block
`timescale 1ns/10ps
module pfp_panel_test;
  logic clk, rst;
  logic [7:0] s_axi_awaddr, s_axi_araddr, hostData, printByte, e;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic onlineKeyN, paperFeedKeyN, paperOut, lampRed, lampGreen;
  logic commandSetJumper, charsetJumper, directionJumper, fontJumper;
  logic hostStrobeN, hostBusy, hostAckN, printValid, printReady, rowActive, feedMotor;
  logic rawBytePrintMode, commandSetB, chineseMode, reverseDirection, largeFont, selfTestActive;
  int nFail, checked, cycles;
  pfp_panel #(.DEBOUNCE_CYCLES(8)) u_pfp_panel (.*);
  pfp_host_model u_pfp_host_model (.clk(clk), .hostBusy(hostBusy), .hostData(hostData),
    .hostStrobeN(hostStrobeN));
  ////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      nFail++;
      report_and_stop();
    end
  end
  ////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checked++;
    if (got !== exp) begin
      nFail++;
      $display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic axiWr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic axiRd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic st(input logic [1:0] x);
    axiRd(pfp_pkg::ADDR_STATUS, rd, rsp);
    chk(rd[1:0], x, "state");
  endtask
  // debounced press: long enough for sync plus an 8-cycle debounce
  task automatic press();
    onlineKeyN <= 1'b0;
    tick(20);
    onlineKeyN <= 1'b1;
    tick(20);
  endtask
  task automatic pulseReady();
    printReady <= 1'b1;
    tick(1);
    printReady <= 1'b0;
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checked, nFail);
    if (nFail == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    {rst, onlineKeyN, paperFeedKeyN} = 3'b111;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h0000000000000f;
    {paperOut, printReady, rowActive, commandSetJumper, charsetJumper} = 5'h00;
    {directionJumper, fontJumper, nFail, checked, cycles} = 98'h0;
    tick(12);
    rst <= 1'b0;
    tick(30);
    chk({lampRed, lampGreen, rawBytePrintMode}, 3'b010, "power-up");
    axiRd(pfp_pkg::ADDR_CTRL, rd, rsp);
    chk(rd[1:0], pfp_pkg::CTRL_RESET, "ctrl reset");
    for (int j = 0; j < 3; j++) begin
      {commandSetJumper, charsetJumper, directionJumper, fontJumper} <= {4{j[0]}};
      tick(10);
      chk({commandSetB, chineseMode, reverseDirection, largeFont}, {j[0], j[0], ~j[0], j[0]}, "jmp");
    end
    $display("done: jumpers");
    paperOut <= 1'b1;
    tick(10);
    chk({lampRed, lampGreen}, 2'b11, "yellow");
    press();
    chk({lampRed, lampGreen, hostBusy}, 3'b101, "red");
    u_pfp_host_model.send(8'h33, 1'b1);
    chk(printValid, 1'b0, "refused");
    paperOut <= 1'b0;
    paperFeedKeyN <= 1'b0;
    tick(20);
    chk({lampRed, lampGreen, feedMotor}, 3'b001, "dark feed");
    paperFeedKeyN <= 1'b1;
    tick(20);
    chk(feedMotor, 1'b0, "feed stop");
    press();
    paperFeedKeyN <= 1'b0;
    tick(20);
    chk({lampGreen, feedMotor}, 2'b10, "online no feed");
    paperFeedKeyN <= 1'b1;
    tick(20);
    $display("done: panel");
    u_pfp_host_model.send(8'h41, 1'b0);
    chk({printValid, printByte, hostBusy}, {1'b1, 8'h41, 1'b1}, "byte");
    pulseReady();
    tick(3);
    chk(hostAckN, 1'b0, "ack");
    tick(700);
    chk({hostAckN, hostBusy}, 2'b10, "ack end");
    axiRd(pfp_pkg::ADDR_COUNT, rd, rsp);
    chk(rd, 32'h1, "count");
    chk(rsp, pfp_pkg::RESP_OKAY, "rd okay");
    $display("done: host");
    rowActive <= 1'b1;
    press();
    st(2'h1);
    chk(lampGreen, 1'b0, "pause dark");
    rowActive <= 1'b0;
    tick(5);
    st(2'h2);
    press();
    st(2'h0);
    axiWr(pfp_pkg::ADDR_CTRL, 32'h2, rsp);
    chk(rsp, pfp_pkg::RESP_OKAY, "wr okay");
    st(2'h2);
    axiWr(pfp_pkg::ADDR_CTRL, 32'h1, rsp);
    press();
    st(2'h2);
    axiRd(pfp_pkg::ADDR_CTRL, rd, rsp);
    chk(rd[1:0], 2'h1, "keys off");
    axiWr(pfp_pkg::ADDR_CTRL, 32'h2, rsp);
    axiWr(8'h0c, 32'h1, rsp);
    chk(rsp, pfp_pkg::RESP_SLVERR, "bad wr");
    axiRd(8'h0c, rd, rsp);
    chk(rsp, pfp_pkg::RESP_SLVERR, "bad rd resp");
    chk(rd, 32'h0, "bad rd data");
    $display("done: pause and registers");
    press();
    paperFeedKeyN <= 1'b0;
    tick(20);
    press();
    paperFeedKeyN <= 1'b1;
    chk(selfTestActive, 1'b1, "self-test");
    printReady <= 1'b1;
    e = 8'h20;
    for (int i = 0; i < 3000 && selfTestActive === 1'b1; i++) begin
      @(posedge clk);
      if (printValid) begin
        chk(printByte, e, "test char");
        e++;
      end
    end
    printReady <= 1'b0;
    tick(5);
    chk({e, selfTestActive, lampGreen}, {8'h7f, 2'b01}, "test end");
    press();
    paperFeedKeyN <= 1'b0;
    tick(20);
    press();
    paperFeedKeyN <= 1'b1;
    chk(selfTestActive, 1'b1, "again");
    press();
    chk({selfTestActive, lampGreen}, 2'b01, "abort");
    $display("done: self-test");
    onlineKeyN <= 1'b0;
    rst <= 1'b1;
    tick(12);
    rst <= 1'b0;
    tick(20);
    onlineKeyN <= 1'b1;
    tick(40);
    chk(rawBytePrintMode, 1'b1, "raw");
    // the strap key stays down past debounce, so it also counts as one press
    st(2'h2);
    axiWr(pfp_pkg::ADDR_CTRL, 32'h2, rsp);
    st(2'h0);
    u_pfp_host_model.send(8'h5a, 1'b0);
    chk({printValid, printByte}, {1'b1, 8'h35}, "hex hi");
    pulseReady();
    tick(2);
    chk({printValid, printByte}, {1'b1, 8'h61}, "hex lo");
    pulseReady();
    tick(3);
    chk(hostAckN, 1'b0, "hex ack");
    $display("done: raw mode");
    report_and_stop();
  end
endmodule
